// ---- src/lsreg_ctrl.sv ----
/*
  Control registers of the current-limit switch and first regulator, and the
  switch, bulk detection, discharge and fault logic they steer.
  Assumes the power sequencer drives the sequencer status on mclk, and host
  writes arrive on mclk from the control interface.
*/
// Function
// - Fault action 00 ignores, 01 disables switch, 10/11 shut system down.
// - Start slot 0 keeps off, 1-14 slot start, 15 start on active.
// - Stop slot 1-14 slot shutdown, 0 and 15 shut down on entering off.
// - Hibernate keep 0 disables switch in hibernate, 1 keeps active setting.
// - Switch off in hibernate: hibernate protection bit enables bulk detection.
// - Switch off in active: active protection bit enables bulk detection.
// - Regulator mode 0 regulates voltage, 1 is switch ignoring voltage select.
// - Float bit 0 discharges disabled regulator output, 1 leaves it floating.
// - All four regulators disabled discharges the first regulator output regardless of float.
// - Voltage code maps 3.3V..1.8V by 100mV, 1.65V..0.9V by 50mV.
// - State machine reloads fields with fixed mask defaults, not software.
`timescale 1ns/1ps
`default_nettype none
`include "lsreg_map.svh"

module lsreg_ctrl
  import lsreg_pkg::*;
#(
  parameter logic [15:0] SWITCH_DEFAULT = `LSREG_SWITCH_RESET,
  parameter logic [15:0] REG1_DEFAULT = `LSREG_REG1_RESET
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Host register access
  input wire lsreg_host_t host,
  input wire logic [7:0] rd_addr,
  output logic [15:0] rd_data,
  // Sequencer status
  input wire lsreg_seq_in_t seq,
  // Analogue status from the switch and other regulators
  input wire logic limit_detect,
  input wire logic reg1_enable,
  input wire logic [2:0] other_reg_enabled,
  // Controls out
  output logic switch_on,
  output logic bulk_detect_en,
  output logic switch_fault_shutdown,
  output logic system_shutdown,
  output logic reg1_switch_mode,
  output logic reg1_discharge,
  output logic [4:0] reg1_voltage_select,
  output logic [15:0] reg1_millivolts
);
  logic [15:0] switch_reg;
  logic [15:0] reg1_reg;
  logic switch_on_reg;
  logic switch_on_next;
  logic fault_reg;
  logic sys_reg;
  logic limit_s1;
  logic limit_s2;
  logic [1:0] switch_fault_action;
  logic [3:0] switch_startup_slot;
  logic [3:0] switch_shutdown_slot;
  logic switch_hibernate_keep;
  logic switch_hibernate_bulk_detect;
  logic switch_active_bulk_detect;
  logic reg1_output_float;
  logic switch_eff;
  logic all_off;
  logic [15:0] mv;

  // Field views
  assign switch_fault_action = switch_reg[`LSREG_ACT_HI:`LSREG_ACT_LO];
  assign switch_startup_slot = switch_reg[`LSREG_EN_HI:`LSREG_EN_LO];
  assign switch_shutdown_slot = switch_reg[`LSREG_SD_HI:`LSREG_SD_LO];
  assign switch_hibernate_keep = switch_reg[`LSREG_HIBKEEP_BIT];
  assign switch_hibernate_bulk_detect = switch_reg[`LSREG_HIBPROT_BIT];
  assign switch_active_bulk_detect = switch_reg[`LSREG_PROT_BIT];
  assign reg1_output_float = reg1_reg[`LSREG_FLOAT_BIT];

  // Switch register: reload by state machine, else host write
  always_ff @(posedge mclk) begin
    if (reset || seq.reload) begin
      switch_reg <= SWITCH_DEFAULT;
    end else if (host.wr && host.addr == `LSREG_ADDR_SWITCH) begin
      switch_reg <= host.wdata & `LSREG_SWITCH_MASK;
    end
  end

  // Regulator register: reload by state machine, else host write
  always_ff @(posedge mclk) begin
    if (reset || seq.reload) begin
      reg1_reg <= REG1_DEFAULT;
    end else if (host.wr && host.addr == `LSREG_ADDR_REG1) begin
      reg1_reg <= host.wdata & `LSREG_REG1_MASK;
    end
  end

  // Read decode; unmapped index reads zero
  always_comb begin
    if (rd_addr == `LSREG_ADDR_SWITCH) begin
      rd_data = switch_reg;
    end else if (rd_addr == `LSREG_ADDR_REG1) begin
      rd_data = reg1_reg;
    end else begin
      rd_data = 16'h0000;
    end
  end

  // Limit detect comes from analogue, synchronise first
  always_ff @(posedge mclk) begin
    if (reset) begin
      limit_s1 <= 1'b0;
      limit_s2 <= 1'b0;
    end else begin
      limit_s1 <= limit_detect;
      limit_s2 <= limit_s1;
    end
  end

  // Sequenced switch state from start and stop slots
  always_comb begin
    switch_on_next = switch_on_reg;
    case (seq.state)
      LSREG_SEQ_START: begin
        if (seq.slot_tick && switch_startup_slot != `LSREG_SLOT_NONE &&
            switch_startup_slot != `LSREG_SLOT_LAST && seq.slot == switch_startup_slot) begin
          switch_on_next = 1'b1;
        end
      end
      LSREG_SEQ_ACTIVE: begin
        if (!switch_on_reg && switch_startup_slot == `LSREG_SLOT_LAST) begin
          switch_on_next = 1'b1;
        end
      end
      LSREG_SEQ_STOP: begin
        if (seq.slot_tick && switch_shutdown_slot != `LSREG_SLOT_NONE &&
            switch_shutdown_slot != `LSREG_SLOT_LAST && seq.slot == switch_shutdown_slot) begin
          switch_on_next = 1'b0;
        end
      end
      default: begin
        switch_on_next = 1'b0;
      end
    endcase
  end

  // Switch state register; fault latch forces it off
  always_ff @(posedge mclk) begin
    if (reset) begin
      switch_on_reg <= 1'b0;
    end else if (fault_reg) begin
      switch_on_reg <= 1'b0;
    end else begin
      switch_on_reg <= switch_on_next;
    end
  end

  // Fault response; held until the sequencer passes through off.
  // A fault in the same cycle as the off clear wins, so no event is lost.
  always_ff @(posedge mclk) begin
    if (reset) begin
      fault_reg <= 1'b0;
      sys_reg <= 1'b0;
    end else begin
      if (limit_s2 && switch_on_reg && switch_fault_action == LSREG_FAULT_SWITCH) begin
        fault_reg <= 1'b1;
      end else if (seq.state == LSREG_SEQ_OFF) begin
        fault_reg <= 1'b0;
      end
      if (limit_s2 && switch_on_reg && switch_fault_action[1]) begin
        sys_reg <= 1'b1;
      end else if (seq.state == LSREG_SEQ_OFF) begin
        sys_reg <= 1'b0;
      end
    end
  end

  // Hibernate may drop the switch; bulk detection picks per mode
  assign switch_eff = switch_on_reg && !(seq.hibernate && !switch_hibernate_keep);
  assign bulk_detect_en = !switch_eff && (seq.hibernate ? switch_hibernate_bulk_detect
                                                        : switch_active_bulk_detect);
  assign switch_on = switch_eff;
  assign switch_fault_shutdown = fault_reg;
  assign system_shutdown = sys_reg;

  // Regulator controls
  assign all_off = !reg1_enable && (other_reg_enabled == 3'b000);
  assign reg1_discharge = !reg1_enable && (!reg1_output_float || all_off);
  assign reg1_switch_mode = reg1_reg[`LSREG_SWMODE_BIT];
  assign reg1_voltage_select = reg1_reg[`LSREG_VSEL_HI:`LSREG_VSEL_LO];
  assign reg1_millivolts = reg1_reg[`LSREG_SWMODE_BIT] ? 16'h0000 : mv;

  lsreg_vsel u_vsel (
    .code(reg1_reg[`LSREG_VSEL_HI:`LSREG_VSEL_LO]),
    .millivolts(mv)
  );

  // Hibernate with keep clear leaves the switch off
  hib_off_a: assert property (@(posedge mclk) disable iff (reset)
    (seq.hibernate && !switch_hibernate_keep) |-> !switch_on)
    else $error("switch on in hibernate with keep clear");

  // Hibernate bulk detect follows its bit
  hib_bulk_a: assert property (@(posedge mclk) disable iff (reset)
    (seq.hibernate && !switch_on) |-> bulk_detect_en == switch_hibernate_bulk_detect)
    else $error("hibernate bulk detect wrong");

  // Active bulk detect follows its bit
  act_bulk_a: assert property (@(posedge mclk) disable iff (reset)
    (!seq.hibernate && !switch_on) |-> bulk_detect_en == switch_active_bulk_detect)
    else $error("active bulk detect wrong");

  // Fault with action 01 turns the switch off two cycles after sync
  fault_off_a: assert property (@(posedge mclk) disable iff (reset || seq.reload)
    (limit_s2 && switch_on_reg && switch_fault_action == 2'b01 && seq.state != LSREG_SEQ_OFF)
      |=> ##1 !switch_on_reg)
    else $error("switch not disabled on fault");

  // System shutdown for action 1x
  fault_sys_a: assert property (@(posedge mclk) disable iff (reset || seq.reload)
    (limit_s2 && switch_on_reg && switch_fault_action[1] && seq.state != LSREG_SEQ_OFF)
      |=> system_shutdown)
    else $error("system shutdown missing");

  // Start slot match turns switch on
  start_slot_a: assert property (@(posedge mclk) disable iff (reset)
    (seq.state == LSREG_SEQ_START && seq.slot_tick && !fault_reg && seq.slot == switch_startup_slot &&
     switch_startup_slot != 4'h0 && switch_startup_slot != 4'hF) |=> switch_on_reg)
    else $error("switch missed start slot");

  // Off state turns switch off
  off_state_a: assert property (@(posedge mclk) disable iff (reset)
    seq.state == LSREG_SEQ_OFF |=> !switch_on_reg)
    else $error("switch on in off state");

  // Discharge when float clear or all regulators off
  discharge_a: assert property (@(posedge mclk) disable iff (reset)
    (!reg1_enable && (!reg1_output_float || other_reg_enabled == 3'b000)) |-> reg1_discharge)
    else $error("discharge missing");

  // Reload restores defaults
  reload_a: assert property (@(posedge mclk) disable iff (reset)
    seq.reload |=> (switch_reg == SWITCH_DEFAULT && reg1_reg == REG1_DEFAULT))
    else $error("reload did not restore defaults");

endmodule : lsreg_ctrl

`default_nettype wire

// ---- src/lsreg_map.svh ----
/*
  Offsets, field positions, reset values and decode constants for the
  limit switch and first regulator control registers.
  Assumes an 8-bit register index and 16-bit register data.
*/
`ifndef LSREG_MAP_SVH
`define LSREG_MAP_SVH

`define LSREG_ADDR_SWITCH 8'hC7
`define LSREG_ADDR_REG1 8'hC8
`define LSREG_ACT_HI 15
`define LSREG_ACT_LO 14
`define LSREG_EN_HI 13
`define LSREG_EN_LO 10
`define LSREG_SD_HI 9
`define LSREG_SD_LO 6
`define LSREG_HIBKEEP_BIT 4
`define LSREG_HIBPROT_BIT 1
`define LSREG_PROT_BIT 0
`define LSREG_SWMODE_BIT 14
`define LSREG_FLOAT_BIT 10
`define LSREG_VSEL_HI 4
`define LSREG_VSEL_LO 0
`define LSREG_SWITCH_MASK 16'hFFD3
`define LSREG_REG1_MASK 16'h441F
`define LSREG_SWITCH_RESET 16'h0003
`define LSREG_REG1_RESET 16'h001C
`define LSREG_SLOT_NONE 4'h0
`define LSREG_SLOT_LAST 4'hF
`define LSREG_MV_HI_BASE 16'd1800
`define LSREG_MV_HI_STEP 16'd100
`define LSREG_MV_LO_BASE 16'd900
`define LSREG_MV_LO_STEP 16'd50

`endif

// ---- src/lsreg_pkg.sv ----
/*
  Types shared by the limit switch and regulator control block.
  Assumes nothing beyond the map header.
*/
`default_nettype none

package lsreg_pkg;

  // Fault response selected by the switch fault action field
  typedef enum logic [1:0] {
    LSREG_FAULT_IGNORE = 2'b00,
    LSREG_FAULT_SWITCH = 2'b01,
    LSREG_FAULT_SYSTEM = 2'b10
  } lsreg_fault_t;

  // Sequencer state as reported by the power state machine
  typedef enum logic [1:0] {
    LSREG_SEQ_OFF = 2'b00,
    LSREG_SEQ_START = 2'b01,
    LSREG_SEQ_ACTIVE = 2'b10,
    LSREG_SEQ_STOP = 2'b11
  } lsreg_seq_t;

  // Sequencer status carried from the power state machine
  typedef struct packed {
    lsreg_seq_t state;
    logic [3:0] slot;
    logic slot_tick;
    logic hibernate;
    logic reload;
  } lsreg_seq_in_t;

  // Register access from the host control interface
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [15:0] wdata;
  } lsreg_host_t;

endpackage : lsreg_pkg

`default_nettype wire

// ---- src/lsreg_vsel.sv ----
/*
  Decodes the five-bit regulator voltage select into millivolts.
  Assumes a purely combinational use by the control block.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lsreg_map.svh"

module lsreg_vsel (
  // Code in
  input wire logic [4:0] code,
  // Millivolts out
  output logic [15:0] millivolts
);
  // Upper half in 100 mV steps from 1.8 V, lower half in 50 mV steps from 0.9 V
  always_comb begin
    if (code[4]) begin
      millivolts = `LSREG_MV_HI_BASE + 16'(code[3:0]) * `LSREG_MV_HI_STEP;
    end else begin
      millivolts = `LSREG_MV_LO_BASE + 16'(code[3:0]) * `LSREG_MV_LO_STEP;
    end
  end
endmodule : lsreg_vsel

`default_nettype wire

// ---- test/limit_switch_ldo_ctrl_regs_test.sv ----
/*
  Self-checking bench for the switch and first regulator control block.
  Assumes the block's default mask values and drives every input itself.
*/
`timescale 1ns/1ps
`default_nettype none

module limit_switch_ldo_ctrl_regs_test import lsreg_pkg::*;;
  logic mclk, reset, limit_detect, reg1_enable;
  lsreg_host_t host;
  lsreg_seq_in_t seq;
  logic [7:0] rd_addr;
  logic [2:0] other_reg_enabled;
  logic [15:0] rd_data, reg1_millivolts;
  logic switch_on, bulk_detect_en, switch_fault_shutdown, system_shutdown, reg1_switch_mode, reg1_discharge;
  logic [4:0] reg1_voltage_select;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;

  lsreg_ctrl dut (.mclk(mclk), .reset(reset), .host(host), .rd_addr(rd_addr), .rd_data(rd_data), .seq(seq),
    .limit_detect(limit_detect), .reg1_enable(reg1_enable), .other_reg_enabled(other_reg_enabled),
    .switch_on(switch_on), .bulk_detect_en(bulk_detect_en), .switch_fault_shutdown(switch_fault_shutdown),
    .system_shutdown(system_shutdown), .reg1_switch_mode(reg1_switch_mode), .reg1_discharge(reg1_discharge),
    .reg1_voltage_select(reg1_voltage_select), .reg1_millivolts(reg1_millivolts));

  // Free-running clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Cuts a hung run short
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      final_report();
    end
  end

  task automatic final_report();
    if (error_cnt == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask : tick

  // One-cycle write strobe, then a quiet cycle so strobes never abut
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    host = {1'b1, a, d};
    tick(1);
    host.wr = 1'b0;
    tick(1);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    rd_addr = a;
    tick(1);
    chk("rd_data", e, rd_data);
  endtask : rd

  function automatic logic [15:0] sw(logic [1:0] act, logic [3:0] en, logic [3:0] sd, logic k, logic hp, logic p);
    return {act, en, sd, 1'b0, k, 2'b00, hp, p};
  endfunction : sw

  task automatic t_regs();
    rd(8'hC7, 16'h0003);
    rd(8'hC8, 16'h001C);
    rd(8'hC9, 16'h0000);
    wr(8'hC7, 16'hFFFF);
    rd(8'hC7, 16'hFFD3);
    wr(8'hC8, 16'hFFFF);
    rd(8'hC8, 16'h441F);
    chk("reg1_switch_mode", 16'h1, reg1_switch_mode);
    chk("reg1_millivolts", 16'h0, reg1_millivolts);
    // Reload and a write to the same register in one cycle: reload wins
    host = {1'b1, 8'hC7, 16'hFFFF};
    seq.reload = 1'b1;
    tick(1);
    host.wr = 1'b0;
    seq.reload = 1'b0;
    rd(8'hC7, 16'h0003);
    rd(8'hC8, 16'h001C);
    chk("reg1_switch_mode", 16'h0, reg1_switch_mode);
  endtask : t_regs

  // Whole voltage code table, both step sizes
  task automatic t_vsel();
    for (int c = 0; c < 32; c++) begin
      wr(8'hC8, 16'(c));
      chk("reg1_voltage_select", 16'(c), reg1_voltage_select);
      chk("reg1_millivolts", (c > 15) ? 16'(1800 + (c - 16) * 100) : 16'(900 + c * 50), reg1_millivolts);
    end
  endtask : t_vsel

  // Slot start and stop at both ends of the slot range, then active and off
  task automatic t_slots();
    for (int i = 0; i < 2; i++) begin
      wr(8'hC7, sw(2'b00, i ? 4'hE : 4'h1, i ? 4'hE : 4'h1, 1'b0, 1'b1, 1'b1));
      seq.slot = i ? 4'hE : 4'h1;
      seq.state = LSREG_SEQ_START;
      seq.slot_tick = 1'b1;
      tick(1);
      seq.slot_tick = 1'b0;
      chk("switch_on", 16'h1, switch_on);
      seq.state = LSREG_SEQ_STOP;
      seq.slot_tick = 1'b1;
      tick(1);
      seq.slot_tick = 1'b0;
      chk("switch_on", 16'h0, switch_on);
      seq.state = LSREG_SEQ_OFF;
      tick(1);
    end
    wr(8'hC7, sw(2'b00, 4'hF, 4'hF, 1'b0, 1'b1, 1'b1));
    seq.state = LSREG_SEQ_ACTIVE;
    tick(2);
    chk("switch_on", 16'h1, switch_on);
    seq.state = LSREG_SEQ_OFF;
    tick(2);
    chk("switch_on", 16'h0, switch_on);
  endtask : t_slots

  task automatic t_hib();
    wr(8'hC7, sw(2'b00, 4'hF, 4'h0, 1'b0, 1'b0, 1'b1));
    seq.state = LSREG_SEQ_ACTIVE;
    tick(2);
    seq.hibernate = 1'b1;
    tick(1);
    chk("switch_on", 16'h0, switch_on);
    chk("bulk_detect_en", 16'h0, bulk_detect_en);
    seq.hibernate = 1'b0;
    seq.state = LSREG_SEQ_OFF;
    tick(2);
    chk("bulk_detect_en", 16'h1, bulk_detect_en);
    wr(8'hC7, sw(2'b00, 4'hF, 4'h0, 1'b1, 1'b1, 1'b0));
    chk("bulk_detect_en", 16'h0, bulk_detect_en);
    seq.hibernate = 1'b1;
    tick(1);
    chk("bulk_detect_en", 16'h1, bulk_detect_en);
    seq.state = LSREG_SEQ_ACTIVE;
    tick(2);
    chk("switch_on", 16'h1, switch_on);
    seq.hibernate = 1'b0;
    seq.state = LSREG_SEQ_OFF;
    tick(2);
  endtask : t_hib

  // Every fault action code, latches cleared through the off state
  task automatic t_fault();
    for (int a = 0; a < 4; a++) begin
      wr(8'hC7, sw(2'(a), 4'hF, 4'h0, 1'b0, 1'b1, 1'b1));
      seq.state = LSREG_SEQ_ACTIVE;
      tick(2);
      limit_detect = 1'b1;
      tick(6);
      chk("switch_fault_shutdown", 16'(a == 1), switch_fault_shutdown);
      chk("system_shutdown", 16'(a > 1), system_shutdown);
      // System shutdown is carried out by the sequencer, so only action 01 drops the switch here
      chk("switch_on", 16'(a != 1), switch_on);
      limit_detect = 1'b0;
      seq.state = LSREG_SEQ_OFF;
      tick(2);
    end
  endtask : t_fault

  task automatic t_dis();
    wr(8'hC8, 16'h0410);
    other_reg_enabled = 3'b010;
    tick(1);
    chk("reg1_discharge", 16'h0, reg1_discharge);
    other_reg_enabled = 3'b000;
    tick(1);
    chk("reg1_discharge", 16'h1, reg1_discharge);
    wr(8'hC8, 16'h0010);
    other_reg_enabled = 3'b111;
    tick(1);
    chk("reg1_discharge", 16'h1, reg1_discharge);
    reg1_enable = 1'b1;
    tick(1);
    chk("reg1_discharge", 16'h0, reg1_discharge);
  endtask : t_dis

  // Reset, then each scenario in turn
  initial begin
    reset = 1'b1;
    host = '0;
    seq = '0;
    rd_addr = 8'h00;
    limit_detect = 1'b0;
    reg1_enable = 1'b0;
    other_reg_enabled = 3'b000;
    tick(13);
    reset = 1'b0;
    tick(1);
    t_regs();
    t_vsel();
    t_slots();
    t_hib();
    t_fault();
    t_dis();
    final_report();
  end
endmodule : limit_switch_ldo_ctrl_regs_test

`default_nettype wire
